// ===== core/shc_command_control.sv
/*
 * Command decoder of a synchronization hub. Software writes bit-coded
 * commands over AHB-Lite; a fixed sequencer forwards them in order
 * (reset, halt, commit, start, trigger) to the enabled member cards, reset to all cards.
 * Assumes the member cards decode the forwarded bundle, share the trigger
 * pulse, and report end of run of the hub card on an asynchronous pin.
 */
`timescale 1ns/1ns

// Contract
// - Command bit 0 fully resets the hub state and all member cards.
// - Command bit 1 commits the setup to hardware without starting.
// - Command bit 2 starts a run, committing changed setup first.
// - Setup writes are ignored while a run is in progress.
// - Command bit 3 arms trigger detection, with start or later.
// - Command bit 4 forces a trigger; with start it acts as software trigger.
// - Command bit 5 disarms detection; later triggers are ignored.
// - A new run starts with trigger detection disarmed unless armed.
// - Command bit 6 ends the run; without a run it does nothing.
// - Hub validates, synchronizes and forwards commands to members in order.
// - A wait completes when the hub-carrying card reaches its state.
// - Clock source 128 runs a card from the hub clock, unsynchronized.
// - A member mask selects cards; the hub card is always enabled.
module shc_command_control (
    input wire logic clock, // System clock, 10 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic hsel, // AHB slave select.
    input wire logic [31:0] haddr, // AHB address.
    input wire logic [1:0] htrans, // AHB transfer type.
    input wire logic hwrite, // AHB write flag.
    input wire logic [2:0] hsize, // AHB transfer size.
    input wire logic [31:0] hwdata, // AHB write data.
    input wire logic hready, // AHB bus ready.
    output logic [31:0] hrdata, // AHB read data.
    output logic hreadyout, // AHB slave ready.
    output logic hresp, // AHB response, always OKAY.
    output shc_pkg::shc_member_cmd_s memberCmd, // Command bundle to members.
    output logic trigOut, // Shared trigger pulse to members.
    output logic hubDirectClock, // Hub-direct clock mode selected.
    input wire logic hubCardDone, // Hub card reached end of run, async pin.
    input wire logic extTrig // External trigger, async pin.
);

    shc_pkg::shc_seq_e state;
    shc_pkg::shc_seq_e next_state;
    logic dataPhase;
    logic [15:0] addrReg;
    logic writeReg;
    logic [shc_pkg::CMD_BITS-1:0] pending;
    logic running;
    logic armed;
    logic dirty;
    logic runDone;
    logic [31:0] clockSource;
    logic [7:0] memberMask;
    logic doneMeta;
    logic doneSync;
    logic doneLast;
    logic trigMeta;
    logic trigSync;
    logic trigLast;

    // Bus decode.
    wire take = hsel && htrans[1] && hready;
    wire dataDone = dataPhase && hreadyout;
    wire writeDone = dataDone && writeReg;
    wire cmdWrite = writeDone && addrReg == shc_pkg::OFF_CARD_COMMAND;
    wire setupOpen = !running && state == shc_pkg::SEQ_IDLE;
    wire nextDataPhase = take || (dataPhase && !hreadyout);
    wire nextBusy = next_state != shc_pkg::SEQ_IDLE;
    wire [15:0] nextAddr = take ? haddr[15:0] : addrReg;
    wire [7:0] effMask = memberMask | shc_pkg::HUB_CARD_BIT;

    // Sequencer step conditions.
    wire doReset = state == shc_pkg::SEQ_RESET && pending[shc_pkg::CMD_FULL_RESET];
    wire doHalt = state == shc_pkg::SEQ_HALT && pending[shc_pkg::CMD_HALT] && running;
    wire doCommit = state == shc_pkg::SEQ_COMMIT && !running
        && (pending[shc_pkg::CMD_COMMIT_SETUP] || (pending[shc_pkg::CMD_RUN] && dirty));
    wire doStart = state == shc_pkg::SEQ_START && pending[shc_pkg::CMD_RUN] && !running;
    wire inTrig = state == shc_pkg::SEQ_TRIG && running;
    wire doDisarm = inTrig && pending[shc_pkg::CMD_DISARM_TRIGGER];
    wire doArm = inTrig && pending[shc_pkg::CMD_ARM_TRIGGER] && !doDisarm;
    wire doForce = inTrig && pending[shc_pkg::CMD_FORCE_TRIGGER];
    wire [shc_pkg::CMD_BITS-1:0] trigCode = {1'b0, doDisarm, doForce, doArm, 3'h0};
    wire hubFinished = doneSync && !doneLast && running;
    wire trigEdge = trigSync && !trigLast;

    // Read data mux.
    logic [31:0] readMux;
    always_comb begin
        case (nextAddr)
            shc_pkg::OFF_CLOCK_SOURCE: readMux = clockSource;
            shc_pkg::OFF_MEMBER_MASK: readMux = {24'h0, effMask};
            shc_pkg::OFF_HUB_STATUS: readMux = {27'h0, state != shc_pkg::SEQ_IDLE, runDone, dirty, armed, running};
            default: readMux = 32'h0;
        endcase
    end

    always_comb begin
        case (state)
            shc_pkg::SEQ_IDLE: next_state = cmdWrite ? shc_pkg::SEQ_RESET : shc_pkg::SEQ_IDLE;
            shc_pkg::SEQ_RESET: next_state = doReset ? shc_pkg::SEQ_IDLE : shc_pkg::SEQ_HALT;
            shc_pkg::SEQ_HALT: next_state = shc_pkg::SEQ_COMMIT;
            shc_pkg::SEQ_COMMIT: next_state = shc_pkg::SEQ_START;
            shc_pkg::SEQ_START: next_state = shc_pkg::SEQ_TRIG;
            shc_pkg::SEQ_TRIG: next_state = shc_pkg::SEQ_IDLE;
            default: next_state = shc_pkg::SEQ_IDLE;
        endcase
    end

    // Two-flop synchronizers for the asynchronous pins.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            {doneMeta, doneSync, doneLast} <= 3'h0;
            {trigMeta, trigSync, trigLast} <= 3'h0;
        end else begin
            {doneMeta, doneSync, doneLast} <= {hubCardDone, doneMeta, doneSync};
            {trigMeta, trigSync, trigLast} <= {extTrig, trigMeta, trigSync};
        end
    end

    // Bus slave. A transfer arriving while the sequencer works is held in
    // its data phase so commands cannot overtake each other.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dataPhase <= 1'b0;
            addrReg <= 16'h0;
            writeReg <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= 32'h0;
            hresp <= 1'b0;
        end else begin
            dataPhase <= nextDataPhase;
            hreadyout <= !(nextDataPhase && nextBusy);
            hrdata <= readMux;
            if (take) begin
                addrReg <= haddr[15:0];
                writeReg <= hwrite;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= shc_pkg::SEQ_IDLE;
            pending <= '0;
        end else begin
            state <= next_state;
            if (cmdWrite) begin
                pending <= hwdata[shc_pkg::CMD_BITS-1:0];
            end
        end
    end

    // Setup registers.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clockSource <= shc_pkg::CLOCK_SOURCE_RESET;
            memberMask <= shc_pkg::MEMBER_MASK_RESET;
            dirty <= 1'b1;
        end else if (doReset) begin
            clockSource <= shc_pkg::CLOCK_SOURCE_RESET;
            memberMask <= shc_pkg::MEMBER_MASK_RESET;
            dirty <= 1'b1;
        end else if (writeDone && setupOpen && addrReg == shc_pkg::OFF_CLOCK_SOURCE) begin
            clockSource <= hwdata;
            dirty <= 1'b1;
        end else if (writeDone && setupOpen && addrReg == shc_pkg::OFF_MEMBER_MASK) begin
            memberMask <= hwdata[7:0] | shc_pkg::HUB_CARD_BIT;
            dirty <= 1'b1;
        end else if (doCommit) begin
            dirty <= 1'b0;
        end
    end

    // The hub-direct flag follows the committed setup only, so a change
    // never reaches the cards in the middle of a sequence.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hubDirectClock <= 1'b0;
        end else if (doReset) begin
            hubDirectClock <= 1'b0;
        end else if (doCommit) begin
            hubDirectClock <= clockSource == shc_pkg::HUB_DIRECT_CLOCK;
        end
    end

    // Run and trigger state.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            running <= 1'b0;
            armed <= 1'b0;
            runDone <= 1'b0;
        end else if (doReset) begin
            running <= 1'b0;
            armed <= 1'b0;
            runDone <= 1'b0;
        end else if (doHalt) begin
            running <= 1'b0;
            armed <= 1'b0;
        end else if (doStart) begin
            running <= 1'b1;
            armed <= 1'b0;
            runDone <= 1'b0;
        end else if (hubFinished) begin
            running <= 1'b0;
            armed <= 1'b0;
            runDone <= 1'b1;
        end else if (doDisarm) begin
            armed <= 1'b0;
        end else if (doArm) begin
            armed <= 1'b1;
        end
    end

    // Forwarded command bundle and shared trigger.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            memberCmd <= '0;
            trigOut <= 1'b0;
        end else begin
            memberCmd <= '0;
            if (doReset) begin
                memberCmd <= '{valid: 1'b1, code: 7'h01, mask: shc_pkg::ALL_MEMBERS};
            end else if (doHalt) begin
                memberCmd <= '{valid: 1'b1, code: 7'h40, mask: effMask};
            end else if (doCommit) begin
                memberCmd <= '{valid: 1'b1, code: 7'h02, mask: effMask};
            end else if (doStart) begin
                memberCmd <= '{valid: 1'b1, code: 7'h04, mask: effMask};
            end else if (doArm || doDisarm || doForce) begin
                memberCmd <= '{valid: 1'b1, code: trigCode, mask: effMask};
            end
            trigOut <= doForce || (trigEdge && running && armed);
        end
    end

    // Assertions.
    sequence cmdAccepted;
        state == shc_pkg::SEQ_IDLE && cmdWrite;
    endsequence

    sequence resetIssued;
        memberCmd.valid && memberCmd.code == 7'h01;
    endsequence

    property resetForwarded;
        @(posedge clock) disable iff (rst)
            cmdAccepted ##0 hwdata[shc_pkg::CMD_FULL_RESET] |-> ##2 resetIssued;
    endproperty

    reset_forward_a: assert property (resetForwarded) else $error("reset command not forwarded");

    commit_clean_a: assert property (
        @(posedge clock) disable iff (rst)
            doCommit |=> !dirty && memberCmd.code == 7'h02
    ) else $error("commit left setup dirty");

    start_commits_a: assert property (
        @(posedge clock) disable iff (rst)
            doStart |-> !dirty
    ) else $error("run started with uncommitted setup");

    setup_locked_a: assert property (
        @(posedge clock) disable iff (rst)
            running && !doReset |=> $stable(clockSource) && $stable(memberMask)
    ) else $error("setup changed during run");

    trig_gated_a: assert property (
        @(posedge clock) disable iff (rst)
            trigOut |-> $past(doForce) || $past(armed && running)
    ) else $error("trigger passed while disarmed");

    start_disarmed_a: assert property (
        @(posedge clock) disable iff (rst)
            doStart |=> running && !armed
    ) else $error("run started armed");

    halt_idle_a: assert property (
        @(posedge clock) disable iff (rst)
            state == shc_pkg::SEQ_HALT && !running |=> !memberCmd.valid
    ) else $error("halt forwarded without a run");

    seq_order_a: assert property (
        @(posedge clock) disable iff (rst)
            cmdAccepted ##0 !hwdata[shc_pkg::CMD_FULL_RESET] |=> ##1 state == shc_pkg::SEQ_HALT
                ##1 state == shc_pkg::SEQ_COMMIT ##1 state == shc_pkg::SEQ_START ##1 state == shc_pkg::SEQ_TRIG
    ) else $error("sequencer order broken");

    hub_done_a: assert property (
        @(posedge clock) disable iff (rst)
            hubFinished && !doReset && !doHalt && !doStart |=> runDone && !running
    ) else $error("hub card completion not seen");

    hub_member_a: assert property (
        @(posedge clock) disable iff (rst)
            memberCmd.valid |-> memberCmd.mask[0]
    ) else $error("hub card left out of forwarded command");

    reset_clears_a: assert property (
        @(posedge clock) disable iff (rst)
            doReset |=> !running && !armed && dirty && !hubDirectClock
                && clockSource == shc_pkg::CLOCK_SOURCE_RESET && memberMask == shc_pkg::MEMBER_MASK_RESET
    ) else $error("full reset left state behind");

    arm_step_a: assert property (
        @(posedge clock) disable iff (rst)
            doArm && !hubFinished |=> armed
    ) else $error("arm command did not arm detection");

    force_pulse_a: assert property (
        @(posedge clock) disable iff (rst)
            doForce |=> trigOut
    ) else $error("forced trigger not issued");

    disarm_wins_a: assert property (
        @(posedge clock) disable iff (rst)
            inTrig && pending[shc_pkg::CMD_DISARM_TRIGGER] |=> !armed && !memberCmd.code[shc_pkg::CMD_ARM_TRIGGER]
    ) else $error("disarm did not win over arm");

    direct_commit_a: assert property (
        @(posedge clock) disable iff (rst)
            doCommit |=> hubDirectClock == ($past(clockSource) == shc_pkg::HUB_DIRECT_CLOCK)
    ) else $error("hub-direct flag not taken at commit");

endmodule

// ===== include/shc_pkg.sv
/*
 * Shared constants and types for the synchronization hub command block:
 * register byte offsets, command bit positions, field reset values,
 * sequencer states and the bundle sent to the member cards.
 * Assumes a 32-bit AHB-Lite register bus and up to eight member cards.
 */
package shc_pkg;

    localparam int MEMBERS = 8;

    // Register byte offsets.
    localparam logic [15:0] OFF_CARD_COMMAND = 16'h0064;
    localparam logic [15:0] OFF_CLOCK_SOURCE = 16'h4ee8;
    localparam logic [15:0] OFF_MEMBER_MASK = 16'hc030;
    localparam logic [15:0] OFF_HUB_STATUS = 16'h0070;

    // Command bit positions inside card_command.
    localparam int CMD_FULL_RESET = 0;
    localparam int CMD_COMMIT_SETUP = 1;
    localparam int CMD_RUN = 2;
    localparam int CMD_ARM_TRIGGER = 3;
    localparam int CMD_FORCE_TRIGGER = 4;
    localparam int CMD_DISARM_TRIGGER = 5;
    localparam int CMD_HALT = 6;
    localparam int CMD_BITS = 7;

    // Clock source value that runs a card straight from the hub clock.
    localparam logic [31:0] HUB_DIRECT_CLOCK = 32'h0000_0080;

    // Reset values of the writable fields.
    localparam logic [31:0] CLOCK_SOURCE_RESET = 32'h0000_0000;
    localparam logic [7:0] MEMBER_MASK_RESET = 8'h01;
    // Logical index 0 is the card that carries the hub.
    localparam logic [7:0] HUB_CARD_BIT = 8'h01;
    localparam logic [7:0] ALL_MEMBERS = 8'hff;

    // Status field positions.
    localparam int ST_RUNNING = 0;
    localparam int ST_ARMED = 1;
    localparam int ST_DIRTY = 2;
    localparam int ST_RUN_DONE = 3;
    localparam int ST_BUSY = 4;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'h0,
        SEQ_RESET = 3'h1,
        SEQ_HALT = 3'h2,
        SEQ_COMMIT = 3'h3,
        SEQ_START = 3'h4,
        SEQ_TRIG = 3'h5
    } shc_seq_e;

    typedef struct packed {
        logic valid;
        logic [CMD_BITS-1:0] code;
        logic [MEMBERS-1:0] mask;
    } shc_member_cmd_s;

endpackage

// ===== sim/shc_command_control_test.sv
/*
 * Self-checking bench of the hub command block: drives AHB-Lite
 * transfers and judges forwarded commands through the member model.
 * Assumes single-slave AHB-Lite with hready tied to hreadyout.
 */
`timescale 1ns/1ns

module shc_command_control_test;
    logic clock = 0, rst = 1, hsel = 0, hwrite = 0, extTrig = 0, clrSeen = 0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic hreadyout, hresp, trigOut, hubDirectClock, hubCardDone;
    shc_pkg::shc_member_cmd_s memberCmd;
    logic [6:0] seen;
    logic [7:0] lastMask, doneDelay = 8'h14;
    int nTrig, t0, fails = 0, n_compared = 0;

    always #50 clock = ~clock;

    shc_command_control dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .memberCmd(memberCmd), .trigOut(trigOut),
        .hubDirectClock(hubDirectClock), .hubCardDone(hubCardDone), .extTrig(extTrig));
    shc_member_model cards (.clock(clock), .rst(rst), .memberCmd(memberCmd), .trigOut(trigOut),
        .clrSeen(clrSeen), .doneDelay(doneDelay), .seen(seen), .lastMask(lastMask), .nTrig(nTrig),
        .hubCardDone(hubCardDone));

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Waits for hready high at a rising edge; only the watchdog ends a stall.
    task rdy;
        @(posedge clock);
        while (hreadyout !== 1'b1) begin
            @(posedge clock);
        end
        rd = hrdata;
    endtask

    task xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {16'h0000, a};
        hwrite <= w;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
    endtask

    task rdchk(input string what, input logic [15:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(what, exp, rd);
        chk("response", 32'h0, hresp);
    endtask

    task cmd(input logic [31:0] c);
        clrSeen <= 1'b1;
        cyc(1);
        clrSeen <= 1'b0;
        t0 = nTrig;
        xfer(1'b1, shc_pkg::OFF_CARD_COMMAND, c);
        cyc(10);
    endtask

    task pulse_ext;
        extTrig <= 1'b1;
        cyc(3);
        extTrig <= 1'b0;
        cyc(8);
    endtask

    task t_reset_values;
        rdchk("status", shc_pkg::OFF_HUB_STATUS, 32'h4);
        rdchk("mask", shc_pkg::OFF_MEMBER_MASK, 32'h1);
        rdchk("clock source", shc_pkg::OFF_CLOCK_SOURCE, 32'h0);
        rdchk("command", shc_pkg::OFF_CARD_COMMAND, 32'h0);
        xfer(1'b1, 16'h0100, 32'hffff_ffff);
        rdchk("unmapped", 16'h0100, 32'h0);
        $display("test reset_values done");
    endtask

    task t_commit;
        // hub-direct clock chosen before any start
        xfer(1'b1, shc_pkg::OFF_CLOCK_SOURCE, shc_pkg::HUB_DIRECT_CLOCK);
        xfer(1'b1, shc_pkg::OFF_MEMBER_MASK, 32'h6);
        rdchk("mask", shc_pkg::OFF_MEMBER_MASK, 32'h7);
        chk("direct before commit", 32'h0, hubDirectClock);
        cmd(32'h2);
        chk("commit code", 32'h2, seen);
        chk("member mask", 32'h7, lastMask);
        chk("direct after commit", 32'h1, hubDirectClock);
        rdchk("status", shc_pkg::OFF_HUB_STATUS, 32'h0);
        $display("test commit done");
    endtask

    task t_run_armed;
        cmd(32'hc);
        chk("start arm code", 32'hc, seen);
        rdchk("status", shc_pkg::OFF_HUB_STATUS, 32'h3);
        xfer(1'b1, shc_pkg::OFF_CLOCK_SOURCE, 32'h0);
        rdchk("clock locked", shc_pkg::OFF_CLOCK_SOURCE, 32'h80);
        pulse_ext();
        chk("ext trigger", t0 + 1, nTrig);
        cyc(30);
        xfer(1'b0, shc_pkg::OFF_HUB_STATUS, 32'h0);
        chk("run done", 32'h8, rd & 32'h9);
        $display("test run_armed done");
    endtask

    task t_full_reset;
        cmd(32'h45);
        chk("reset alone", 32'h1, seen);
        chk("direct after reset", 32'h0, hubDirectClock);
        rdchk("status", shc_pkg::OFF_HUB_STATUS, 32'h4);
        rdchk("mask", shc_pkg::OFF_MEMBER_MASK, 32'h1);
        rdchk("clock source", shc_pkg::OFF_CLOCK_SOURCE, 32'h0);
        $display("test full_reset done");
    endtask

    task t_run_forced;
        doneDelay <= 8'h00;
        cmd(32'h4);
        chk("auto commit", 32'h6, seen);
        rdchk("status", shc_pkg::OFF_HUB_STATUS, 32'h1);
        pulse_ext();
        chk("unarmed trigger", t0, nTrig);
        cmd(32'h10);
        chk("forced trigger", t0 + 1, nTrig);
        cmd(32'h40);
        chk("halt code", 32'h40, seen);
        cmd(32'h40);
        chk("idle halt", 32'h0, seen);
        $display("test run_forced done");
    endtask

    task t_disarm;
        cmd(32'h14);
        chk("soft trigger", t0 + 1, nTrig);
        cmd(32'h8);
        cmd(32'h20);
        chk("disarm code", 32'h20, seen);
        pulse_ext();
        chk("disarmed trigger", t0, nTrig);
        cmd(32'h40);
        xfer(1'b0, shc_pkg::OFF_HUB_STATUS, 32'h0);
        chk("stopped", 32'h0, rd & 32'h3);
        $display("test disarm done");
    endtask

    task test_done;
        $display("counts: %0d compared, %0d failed", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        cyc(5);
        rst <= 1'b0;
        cyc(1);
        t_reset_values();
        t_commit();
        t_run_armed();
        t_full_reset();
        t_run_forced();
        t_disarm();
        test_done();
    end

    // The tests need well under 3000 cycles; this cuts a hang short.
    initial begin
        #1000000;
        fails++;
        test_done();
    end
endmodule

// ===== sim/shc_member_model.sv
/*
 * Behavioural model of the member cards behind the hub: logs forwarded
 * commands, counts shared triggers and ends the hub card's run.
 * Assumes one clock shared with the hub and the hub's bundle format.
 */
`timescale 1ns/1ns

module shc_member_model (
    input wire logic clock, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire shc_pkg::shc_member_cmd_s memberCmd, // Bundle from the hub.
    input wire logic trigOut, // Shared trigger pulse.
    input wire logic clrSeen, // Clears the command log.
    input wire logic [7:0] doneDelay, // Cycles from trigger to run end, 0 never.
    output logic [6:0] seen, // Commands seen since the last clear.
    output logic [7:0] lastMask, // Mask of the last bundle.
    output int nTrig, // Triggers seen.
    output logic hubCardDone // Hub card reached end of run.
);
    logic running;
    logic triggered;
    logic [7:0] cnt;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            seen <= '0;
            lastMask <= '0;
            nTrig <= 0;
            running <= 1'b0;
            triggered <= 1'b0;
            cnt <= '0;
            hubCardDone <= 1'b0;
        end else begin
            if (clrSeen) begin
                seen <= '0;
            end else if (memberCmd.valid) begin
                seen <= seen | memberCmd.code;
            end
            if (memberCmd.valid) begin
                lastMask <= memberCmd.mask;
            end
            if (trigOut) begin
                nTrig <= nTrig + 1;
            end
            // run end by reset, halt or end of data
            if (memberCmd.valid && (memberCmd.code[shc_pkg::CMD_FULL_RESET] || memberCmd.code[shc_pkg::CMD_HALT])) begin
                running <= 1'b0;
                hubCardDone <= 1'b0;
            end else if (memberCmd.valid && memberCmd.code[shc_pkg::CMD_RUN]) begin
                // hub card starts with the group
                running <= 1'b1;
                triggered <= 1'b0;
                cnt <= '0;
                hubCardDone <= 1'b0;
            end else if (running && (triggered || trigOut)) begin
                triggered <= 1'b1;
                cnt <= cnt + 8'h01;
                if (doneDelay != 8'h00 && cnt == doneDelay) begin
                    hubCardDone <= 1'b1;
                    running <= 1'b0;
                end
            end
        end
    end
endmodule
